// file: shared/iar_pkg.sv
package iar_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses, one aligned word each)
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] DELAY_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] INT_STATUS_OFS = 8'h0C;
    localparam logic [7:0] INT_CLEAR_OFS = 8'h10;
    localparam logic [7:0] INT_ENABLE_OFS = 8'h14;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int CTRL_ACK_EN_BIT = 0;
    localparam int CTRL_PREV_FS_BIT = 1;
    localparam int CTRL_INS_FS_BIT = 2;
    localparam logic [2:0] CTRL_RST = 3'h1;

    // ------------------------------------------------------------
    // Alarm delay, counted in millisecond ticks
    // ------------------------------------------------------------
    localparam int DELAY_W = 16;
    localparam logic [15:0] DELAY_RST = 16'h03E8;
    localparam int CLK_PERIOD_NS = 100;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------
    localparam int STS_STATE_LSB = 0;
    localparam int STS_PREV_ALARM_BIT = 4;
    localparam int STS_INS_ALARM_BIT = 5;
    localparam int STS_PREV_LED_BIT = 6;
    localparam int STS_INS_LED_BIT = 7;
    localparam int STS_PREV_RELAY_BIT = 8;
    localparam int STS_INS_RELAY_BIT = 9;
    localparam int STS_FAULT_IN_BIT = 10;
    localparam int STS_PREV_IN_BIT = 11;

    // ------------------------------------------------------------
    // Interrupt events
    // ------------------------------------------------------------
    localparam int EV_W = 4;
    localparam int EV_PREV_BIT = 0;
    localparam int EV_ALARM_BIT = 1;
    localparam int EV_ACK_BIT = 2;
    localparam int EV_CORR_BIT = 3;
    localparam logic [3:0] INT_EN_RST = 4'h0;

    // ------------------------------------------------------------
    // Alarm sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_NORMAL,
        ST_PREV,
        ST_DELAY,
        ST_ALARM,
        ST_ACKED
    } iar_state_t;

endpackage

// file: verilog/iar_delay_timer.sv
`timescale 1ns/1ps
module iar_delay_timer
    import iar_pkg::*;
#(
    parameter int TICKS = TICK_CYCLES
)
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic run_i,
    input wire logic [DELAY_W-1:0] delay_i,
    output logic done_o
);

    // ------------------------------------------------------------
    // Millisecond prescaler and delay counter
    // ------------------------------------------------------------
    logic [31:0] pre_r;
    logic [DELAY_W-1:0] ms_r;
    logic tick;
    logic at_limit;

    assign tick = (pre_r == 32'(TICKS - 1));
    assign at_limit = (ms_r >= delay_i);

    // Done is a level while running; a zero delay expires at once
    assign done_o = run_i & at_limit;

    // Both counters restart whenever run drops, so each fault gets the full delay
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            pre_r <= 32'h0000_0000;
            ms_r <= 16'h0000;
        end
        else if (!run_i)
        begin
            pre_r <= 32'h0000_0000;
            ms_r <= 16'h0000;
        end
        else
        begin
            pre_r <= tick ? 32'h0000_0000 : pre_r + 32'h0000_0001;
            if (tick && !at_limit)
            begin
                ms_r <= ms_r + 16'h0001;
            end
        end
    end

endmodule

// file: verilog/iar_alarm_relay.sv
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/1ps
// Summary of operation
// (RULE1) Acknowledge enable setting, on after reset
// (RULE2) Preventive threshold crossed: relay and light on
// (RULE3) Fault held for delay: alarm relay and LED
// (RULE4) Ack enabled: press returns both relays rest
// (RULE5) Ack disabled: press leaves relays switched
// (RULE6) Ack disabled: relays rest only on recovery
// (RULE7) Fault corrected: LED off, back to normal
// (RULE8) Per-relay failsafe or standard coil polarity
module iar_alarm_relay
    import iar_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
)
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic prev_below_i,
    input wire logic fault_i,
    input wire logic ack_button_i,
    output logic prev_relay_o,
    output logic ins_relay_o,
    output logic prev_led_o,
    output logic ins_led_o,
    output logic irq_o
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Coil drive: failsafe coils sit energized at rest and drop on alarm
    function automatic logic relay_coil(input logic alarm, input logic failsafe);
        relay_coil = failsafe ? ~alarm : alarm;
    endfunction

    // Word address match on the low address byte
    function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] ofs);
        addr_is = (addr[7:2] == ofs[7:2]);
    endfunction

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [2:0] ctrl_r;
    logic [DELAY_W-1:0] delay_r;
    logic [EV_W-1:0] int_sts_r;
    logic [EV_W-1:0] int_sts_nxt;
    logic [EV_W-1:0] int_en_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    iar_state_t state_r;
    iar_state_t state_nxt;
    logic prev_ack_r;
    logic prev_ack_nxt;
    logic ack_btn_r;
    logic prev_relay_r;
    logic ins_relay_r;
    logic prev_led_r;
    logic ins_led_r;
    logic prev_alarm_d_r;

    logic setup;
    logic wr_access;
    logic hit_ctrl;
    logic hit_delay;
    logic hit_status;
    logic hit_int_sts;
    logic hit_int_clr;
    logic hit_int_en;
    logic mapped;
    logic [31:0] rd_mux;
    logic [EV_W-1:0] clr_mask;
    logic [EV_W-1:0] events;
    logic ack_en;
    logic ack_press;
    logic timer_done;
    logic prev_alarm;
    logic ins_alarm;
    logic ins_led;
    logic corrected;
    logic ack_taken;
    iar_state_t rest_state;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------

    // Zero wait state slave: every access completes in its first access cycle
    assign pready_o = 1'b1;
    assign setup = psel_i & ~penable_i;
    assign wr_access = psel_i & penable_i & pwrite_i;
    assign hit_ctrl = addr_is(paddr_i, CTRL_OFS);
    assign hit_delay = addr_is(paddr_i, DELAY_OFS);
    assign hit_status = addr_is(paddr_i, STATUS_OFS);
    assign hit_int_sts = addr_is(paddr_i, INT_STATUS_OFS);
    assign hit_int_clr = addr_is(paddr_i, INT_CLEAR_OFS);
    assign hit_int_en = addr_is(paddr_i, INT_ENABLE_OFS);
    assign mapped = hit_ctrl | hit_delay | hit_status | hit_int_sts | hit_int_clr | hit_int_en;
    assign pslverr_o = pslverr_r;
    assign prdata_o = prdata_r;

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------

    // Control and delay written at the access cycle only
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            ctrl_r <= CTRL_RST; // see (RULE1)
            delay_r <= DELAY_RST;
            int_en_r <= INT_EN_RST;
        end
        else if (wr_access)
        begin
            if (hit_ctrl)
            begin
                ctrl_r <= pwdata_i[2:0]; // see (RULE1) (RULE8)
            end
            if (hit_delay)
            begin
                delay_r <= pwdata_i[DELAY_W-1:0];
            end
            if (hit_int_en)
            begin
                int_en_r <= pwdata_i[EV_W-1:0];
            end
        end
    end

    assign ack_en = ctrl_r[CTRL_ACK_EN_BIT];

    // Only the press edge counts, so a held button acknowledges once
    assign ack_press = ack_button_i & ~ack_btn_r;

    // ------------------------------------------------------------
    // Insulation alarm delay
    // ------------------------------------------------------------
    iar_delay_timer #(
        .TICKS(TICK_CYCLES_P)
    ) u_delay (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .run_i(state_r == ST_DELAY),
        .delay_i(delay_r),
        .done_o(timer_done)
    );

    // ------------------------------------------------------------
    // Alarm sequencer
    // ------------------------------------------------------------

    // Where the block lands once the fault is gone
    assign rest_state = prev_below_i ? ST_PREV : ST_NORMAL;

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_NORMAL:
            begin
                if (fault_i)
                begin
                    state_nxt = ST_DELAY;
                end
                else if (prev_below_i)
                begin
                    state_nxt = ST_PREV; // see (RULE2)
                end
            end
            ST_PREV:
            begin
                if (fault_i)
                begin
                    state_nxt = ST_DELAY;
                end
                else if (!prev_below_i)
                begin
                    state_nxt = ST_NORMAL;
                end
            end
            ST_DELAY:
            begin
                // A fault that clears before the delay never raises the alarm
                if (!fault_i)
                begin
                    state_nxt = rest_state;
                end
                else if (timer_done)
                begin
                    state_nxt = ST_ALARM; // see (RULE3)
                end
            end
            ST_ALARM:
            begin
                if (!fault_i)
                begin
                    state_nxt = rest_state; // see (RULE6) (RULE7)
                end
                else if (ack_press && ack_en)
                begin
                    state_nxt = ST_ACKED; // see (RULE4)
                end
                // With ack disabled the press is ignored; see (RULE5)
            end
            ST_ACKED:
            begin
                if (!fault_i)
                begin
                    state_nxt = rest_state; // see (RULE7)
                end
            end
            default:
            begin
                state_nxt = ST_NORMAL;
            end
        endcase
    end

    assign ack_taken = (state_r == ST_ALARM) && (state_nxt == ST_ACKED);
    assign corrected = ((state_r == ST_ALARM) || (state_r == ST_ACKED)) && !fault_i;

    // Preventive relay stays muted after an ack until its own threshold recovers
    always_comb
    begin
        prev_ack_nxt = prev_ack_r;
        if (!prev_below_i)
        begin
            prev_ack_nxt = 1'b0;
        end
        else if (ack_taken)
        begin
            prev_ack_nxt = 1'b1; // see (RULE4)
        end
    end

    // Sequencer state, button history and sticky events; button resets released, so no false press
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state_r <= ST_NORMAL;
            prev_ack_r <= 1'b0;
            ack_btn_r <= 1'b0;
            int_sts_r <= 4'h0;
        end
        else
        begin
            state_r <= state_nxt;
            prev_ack_r <= prev_ack_nxt;
            ack_btn_r <= ack_button_i;
            int_sts_r <= int_sts_nxt;
        end
    end

    // ------------------------------------------------------------
    // Relay and indicator drive
    // ------------------------------------------------------------

    // Logical alarm levels, before coil polarity is applied
    assign prev_alarm = prev_below_i & ~prev_ack_nxt; // see (RULE2) (RULE4) (RULE6)
    assign ins_alarm = (state_nxt == ST_ALARM); // see (RULE3) (RULE4) (RULE5)
    // LED stays lit through an ack; only the recovery puts it out
    assign ins_led = (state_nxt == ST_ALARM) || (state_nxt == ST_ACKED); // see (RULE7)

    // Registered outputs avoid glitches on the relay coils
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            prev_relay_r <= 1'b0;
            ins_relay_r <= 1'b0;
            prev_led_r <= 1'b0;
            ins_led_r <= 1'b0;
            prev_alarm_d_r <= 1'b0;
        end
        else
        begin
            prev_relay_r <= relay_coil(prev_alarm, ctrl_r[CTRL_PREV_FS_BIT]); // see (RULE8)
            ins_relay_r <= relay_coil(ins_alarm, ctrl_r[CTRL_INS_FS_BIT]); // see (RULE8)
            prev_led_r <= prev_below_i; // see (RULE2)
            ins_led_r <= ins_led; // see (RULE3)
            prev_alarm_d_r <= prev_alarm;
        end
    end

    assign prev_relay_o = prev_relay_r;
    assign ins_relay_o = ins_relay_r;
    assign prev_led_o = prev_led_r;
    assign ins_led_o = ins_led_r;

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    assign events[EV_PREV_BIT] = prev_alarm & ~prev_alarm_d_r;
    assign events[EV_ALARM_BIT] = (state_r == ST_DELAY) && (state_nxt == ST_ALARM);
    assign events[EV_ACK_BIT] = ack_taken;
    assign events[EV_CORR_BIT] = corrected;

    assign clr_mask = (wr_access && hit_int_clr) ? pwdata_i[EV_W-1:0] : 4'h0;
    // A new event in the clearing cycle survives the clear
    assign int_sts_nxt = (int_sts_r & ~clr_mask) | events;

    assign irq_o = |(int_sts_r & int_en_r);

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (hit_ctrl)
        begin
            rd_mux[2:0] = ctrl_r;
        end
        else if (hit_delay)
        begin
            rd_mux[DELAY_W-1:0] = delay_r;
        end
        else if (hit_status)
        begin
            rd_mux[STS_STATE_LSB +: 3] = state_r;
            rd_mux[STS_PREV_ALARM_BIT] = prev_alarm_d_r;
            rd_mux[STS_INS_ALARM_BIT] = (state_r == ST_ALARM);
            rd_mux[STS_PREV_LED_BIT] = prev_led_r;
            rd_mux[STS_INS_LED_BIT] = ins_led_r;
            rd_mux[STS_PREV_RELAY_BIT] = prev_relay_r;
            rd_mux[STS_INS_RELAY_BIT] = ins_relay_r;
            rd_mux[STS_FAULT_IN_BIT] = fault_i;
            rd_mux[STS_PREV_IN_BIT] = prev_below_i;
        end
        else if (hit_int_sts)
        begin
            rd_mux[EV_W-1:0] = int_sts_r;
        end
        else if (hit_int_en)
        begin
            rd_mux[EV_W-1:0] = int_en_r;
        end
    end

    // Captured in setup so data and error are stable through the access cycle
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end
        else if (setup)
        begin
            prdata_r <= pwrite_i ? 32'h0000_0000 : rd_mux;
            pslverr_r <= ~mapped;
        end
    end

endmodule

// file: test/iar_panel_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Front panel and relay loads
// ------------------------------------------------------------
module iar_panel_model
(
    input wire logic clk_i,
    input wire logic prev_relay_i,
    input wire logic ins_relay_i,
    output logic ack_button_o,
    output logic [1:0] lamp_o
);
    // Lamps follow coil current, so a failsafe coil lights them at rest
    assign lamp_o = {ins_relay_i, prev_relay_i};

    // Button idles released
    initial ack_button_o = 1'b0;

    // One press, held for a few cycles like a finger would
    task automatic press(input int hold);
        @(posedge clk_i);
        ack_button_o <= 1'b1;
        repeat (hold) @(posedge clk_i);
        ack_button_o <= 1'b0;
    endtask
endmodule

// file: test/iar_alarm_relay_checker.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Alarm relay checker
// ------------------------------------------------------------
module iar_alarm_relay_checker
    import iar_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
)
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic pready_o,
    input wire logic prev_below_i,
    input wire logic fault_i,
    input wire logic ack_button_i,
    input wire logic prev_relay_o,
    input wire logic ins_relay_o,
    input wire logic prev_led_o,
    input wire logic ins_led_o
);
    logic [2:0] ctrl_r;
    logic [15:0] delay_r;
    int fault_cnt_r;
    wire wr_done = psel_i && penable_i && pwrite_i && pready_o;
    wire ctrl_hit = wr_done && (paddr_i[7:2] == CTRL_OFS[7:2]);
    wire delay_hit = wr_done && (paddr_i[7:2] == DELAY_OFS[7:2]);

    // Shadow of control, kept from completed writes only
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            ctrl_r <= CTRL_RST;
        else if (ctrl_hit)
            ctrl_r <= pwdata_i[2:0];
    end

    // Shadow of the alarm delay
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            delay_r <= DELAY_RST;
        else if (delay_hit)
            delay_r <= pwdata_i[15:0];
    end

    // Length of the present fault, bounds the alarm delay both ways
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            fault_cnt_r <= 0;
        else
            fault_cnt_r <= fault_i ? fault_cnt_r + 1 : 0;
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    // Press in alarm, and both coils back at their rest level
    sequence s_press;
        $rose(ack_button_i) && ins_led_o && fault_i;
    endsequence
    sequence s_rest;
        prev_relay_o == $past(ctrl_r[CTRL_PREV_FS_BIT]) && ins_relay_o == $past(ctrl_r[CTRL_INS_FS_BIT]);
    endsequence

    property p_prev_light;
        $rose(prev_below_i) |=> prev_led_o;
    endproperty
    property p_prev_relay;
        $rose(prev_below_i) && !fault_i && !ins_led_o |=> prev_relay_o != $past(ctrl_r[CTRL_PREV_FS_BIT]);
    endproperty
    property p_alarm_relay;
        $rose(ins_led_o) |-> ins_relay_o != $past(ctrl_r[CTRL_INS_FS_BIT]);
    endproperty
    property p_not_early;
        $rose(ins_led_o) |-> fault_cnt_r + TICK_CYCLES_P >= delay_r * TICK_CYCLES_P;
    endproperty
    property p_not_late;
        fault_i && fault_cnt_r == delay_r * TICK_CYCLES_P + 2 |-> ins_led_o;
    endproperty
    property p_ack_on;
        s_press ##0 ctrl_r[CTRL_ACK_EN_BIT] |=> s_rest;
    endproperty
    property p_ack_off;
        s_press ##0 !ctrl_r[CTRL_ACK_EN_BIT] |=> (ins_relay_o != ctrl_r[CTRL_INS_FS_BIT])[*3];
    endproperty
    property p_hold_off;
        ins_led_o && fault_i && !ctrl_r[CTRL_ACK_EN_BIT] |=> ins_relay_o != $past(ctrl_r[CTRL_INS_FS_BIT]);
    endproperty
    property p_led_off;
        ins_led_o && !fault_i |=> !ins_led_o;
    endproperty
    property p_rest;
        !prev_below_i && !fault_i |=> s_rest;
    endproperty

    a_prev_light: assert property (p_prev_light) else $error("preventive light missed");
    a_prev_relay: assert property (p_prev_relay) else $error("preventive relay missed");
    a_alarm_relay: assert property (p_alarm_relay) else $error("alarm relay not switched");
    a_not_early: assert property (p_not_early) else $error("alarm before delay");
    a_not_late: assert property (p_not_late) else $error("alarm after delay");
    a_ack_on: assert property (p_ack_on) else $error("ack left relays switched");
    a_ack_off: assert property (p_ack_off) else $error("ack released relay");
    a_hold_off: assert property (p_hold_off) else $error("relay left alarm early");
    a_led_off: assert property (p_led_off) else $error("alarm LED stayed on");
    a_rest: assert property (p_rest) else $error("relay not at rest");
endmodule

bind iar_alarm_relay iar_alarm_relay_checker #(.TICK_CYCLES_P(TICK_CYCLES_P)) u_chk (
    .clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o), .prev_below_i(prev_below_i),
    .fault_i(fault_i), .ack_button_i(ack_button_i), .prev_relay_o(prev_relay_o),
    .ins_relay_o(ins_relay_o), .prev_led_o(prev_led_o), .ins_led_o(ins_led_o));

// file: test/tb_insulation_alarm_relay_ack.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Alarm sequencer bench
// ------------------------------------------------------------
module tb_insulation_alarm_relay_ack
    import iar_pkg::*;
;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic prev_below = 1'b0;
    logic fault = 1'b0;
    logic [31:0] prdata, q;
    logic pready, pslverr, ack, prev_relay, ins_relay, prev_led, ins_led, irq, e;
    logic [2:0] fs;
    int failures = 0;
    int tests_run = 0;

    // Short millisecond tick keeps the delay about a dozen cycles
    iar_alarm_relay #(.TICK_CYCLES_P(4)) DUT (.clk_i(clk), .rstn_i(rstn), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .prev_below_i(prev_below), .fault_i(fault),
        .ack_button_i(ack), .prev_relay_o(prev_relay), .ins_relay_o(ins_relay), .prev_led_o(prev_led),
        .ins_led_o(ins_led), .irq_o(irq));
    iar_panel_model u_panel (.clk_i(clk), .prev_relay_i(prev_relay), .ins_relay_i(ins_relay),
        .ack_button_o(ack), .lamp_o());

    // 10 MHz clock
    always #50 clk = ~clk;

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50)
        begin
            failures++;
            tally_and_finish();
        end
    endtask

    // Bounded wait for the alarm LED
    task automatic wait_led();
        int n;
        n = 0;
        while (ins_led !== 1'b1 && n < 200)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 200)
        begin
            failures++;
            tally_and_finish();
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        apb(1'b0, CTRL_OFS, 32'h0000_0000);
        chk("ctrl_reset", q, 32'h0000_0001);
        apb(1'b0, DELAY_OFS, 32'h0000_0000);
        chk("delay_reset", q, 32'h0000_03E8);
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk("unmapped_err", 32'(e), 32'h0000_0001);
        // Mode 0 ack on, standard coils; mode 1 ack off, failsafe, irq masked
        for (int m = 0; m < 2; m++)
        begin
            fs = (m == 0) ? 3'h1 : 3'h6;
            apb(1'b1, CTRL_OFS, 32'(fs));
            apb(1'b1, DELAY_OFS, 32'h0000_0003);
            apb(1'b1, INT_ENABLE_OFS, (m == 0) ? 32'h0000_000F : 32'h0000_0000);
            repeat (2) @(posedge clk);
            chk("prev_rest", 32'(prev_relay), 32'(fs[1]));
            chk("ins_rest", 32'(ins_relay), 32'(fs[2]));
            prev_below <= 1'b1;
            repeat (3) @(posedge clk);
            chk("prev_relay", 32'(prev_relay), 32'(!fs[1]));
            chk("prev_led", 32'(prev_led), 32'h0000_0001);
            fault <= 1'b1;
            @(posedge clk);
            wait_led();
            chk("ins_relay", 32'(ins_relay), 32'(!fs[2]));
            chk("irq_alarm", 32'(irq), (m == 0) ? 32'h0000_0001 : 32'h0000_0000);
            u_panel.press(2);
            repeat (3) @(posedge clk);
            chk("prev_ack", 32'(prev_relay), 32'((m == 0) ? fs[1] : !fs[1]));
            chk("ins_ack", 32'(ins_relay), 32'((m == 0) ? fs[2] : !fs[2]));
            chk("led_ack", 32'(ins_led), 32'h0000_0001);
            fault <= 1'b0;
            prev_below <= 1'b0;
            repeat (3) @(posedge clk);
            chk("led_corr", 32'(ins_led), 32'h0000_0000);
            chk("prev_corr", 32'(prev_relay), 32'(fs[1]));
            chk("ins_corr", 32'(ins_relay), 32'(fs[2]));
            apb(1'b0, INT_STATUS_OFS, 32'h0000_0000);
            chk("int_status", q, (m == 0) ? 32'h0000_000F : 32'h0000_000B);
            apb(1'b1, INT_CLEAR_OFS, 32'h0000_000F);
            apb(1'b0, INT_STATUS_OFS, 32'h0000_0000);
            chk("int_cleared", q, 32'h0000_0000);
            chk("irq_cleared", 32'(irq), 32'h0000_0000);
        end
        tally_and_finish();
    end
endmodule
